//--- rtl/eisc_pkg.sv
// Package with the register map, field positions and reset values of the external interrupt status/control block.
package eisc_pkg;

  // Avalon byte address width and data width.
  localparam int unsigned EISC_ADDR_W = 4;
  localparam int unsigned EISC_DATA_W = 32;

  // Register byte addresses, one aligned word each.
  localparam logic [EISC_ADDR_W-1:0] EISC_STAT_CTRL_ADDR = 4'h0;
  localparam logic [EISC_ADDR_W-1:0] EISC_BREAK_CTRL_ADDR = 4'h4;
  localparam logic [EISC_ADDR_W-1:0] EISC_LATCH_STAT_ADDR = 4'h8;

  // Field positions in the status/control register.
  localparam int unsigned EISC_PIN_B_LEVEL_BIT = 7;
  localparam int unsigned EISC_PIN_B_CLEAR_BIT = 6;
  localparam int unsigned EISC_PIN_B_BLOCK_BIT = 5;
  localparam int unsigned EISC_PIN_B_SENSE_BIT = 4;
  localparam int unsigned EISC_PIN_B_OFF_BIT = 3;
  localparam int unsigned EISC_PIN_A_CLEAR_BIT = 2;
  localparam int unsigned EISC_PIN_A_BLOCK_BIT = 1;
  localparam int unsigned EISC_PIN_A_SENSE_BIT = 0;

  // Field position in the break control register.
  localparam int unsigned EISC_BREAK_ALLOW_BIT = 0;

  // Field positions in the latch status register.
  localparam int unsigned EISC_LATCH_A_BIT = 0;
  localparam int unsigned EISC_LATCH_B_BIT = 1;
  localparam int unsigned EISC_PIN_A_LEVEL_BIT = 2;

  // Reset values of the stored control fields, of the pin path and of the bus wait flag.
  localparam logic EISC_CTRL_RST = 1'h0;
  localparam logic EISC_PIN_IDLE = 1'h1;
  localparam logic EISC_WAIT_RST = 1'h1;

  // Pin synchroniser depth.
  localparam int unsigned EISC_SYNC_DEPTH = 3;

  // Pin indices in the per-pin vectors.
  localparam int unsigned EISC_PIN_A = 0;
  localparam int unsigned EISC_PIN_B = 1;

  // Whole state of the block, registered in one process.
  typedef struct packed {
    logic [1:0][EISC_SYNC_DEPTH-1:0] sync;
    logic [1:0] lvl;
    logic [1:0] latch;
    logic [1:0] ack_seen;
    logic [1:0] block;
    logic [1:0] sense;
    logic latch_off;
    logic brk_allow;
    logic bus_wait;
    logic [EISC_DATA_W-1:0] rdata;
    logic [1:0] req;
  } eisc_state_t;

endpackage

//--- rtl/eisc_top.sv
// External interrupt status/control block with an Avalon-MM register slave.
//
// Operation
// [RQ1] Read-only bit shows pin B level.
// [RQ2] Writing 1 clears the pin B latch.
// [RQ3] Pin B clear bit reads zero.
// [RQ4] Pin B block bit stops pin B requests.
// [RQ5] Pin B sense: edge-plus-level or edge only.
// [RQ6] Pin B latch-off stops pin B latching.
// [RQ7] Writing 1 clears the pin A latch.
// [RQ8] Pin A clear bit reads zero.
// [RQ9] Pin A block bit stops pin A requests.
// [RQ10] Pin A sense: edge-plus-level or edge only.
// [RQ11] Vector fetch clears its latch; reset clears both.
// [RQ12] Level mode: clear needs acknowledge and pin high.
// [RQ13] Falling edge after acknowledge sets latch again.
// [RQ14] Break blocks software clears unless clear allowed.
// [RQ15] Pins synchronised; falling edge from accepted samples.
`timescale 1ns/1ps
`default_nettype none

module eisc_top
  import eisc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ext_int_pin_a,
  input wire logic ext_int_pin_b,
  input wire logic vec_ack_a,
  input wire logic vec_ack_b,
  input wire logic break_active,
  input wire logic [EISC_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [EISC_DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [EISC_DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic irq_req_a,
  output logic irq_req_b
);

  // Timing seen by users of this block: a pin change is accepted three edges late, so a pulse
  // shorter than about two cycles may be lost, which is the price of filtering pin noise.
  // A request rises on the edge that accepts a falling level; a vector acknowledge or a taken
  // software clear acts on the edge that samples it, so the latch reads low one cycle later.
  // Every bus access costs exactly one wait cycle. Capturing read data on the request edge
  // keeps the answer path free of address decode, at the cost of a slower polling loop.
  // A write lands on its answer edge, so a read that follows it always sees the new value.

  // Registered state and its next value.
  eisc_state_t state_reg;
  eisc_state_t state_next;

  // Per-pin helper terms, visible to the checks below.
  logic [1:0] fall;
  logic [1:0] set_ev;
  logic [1:0] sw_clr_raw;
  logic [1:0] sw_clr;
  logic [1:0] vec_ack;
  logic [1:0] pin_high;
  logic [1:0] hold_low;
  // Bus strobes: a write lands on the answer edge, a read is sampled on the request edge.
  logic wr_take;
  logic rd_take;

  // Vector acknowledges come from the CPU on this clock, so they need no synchroniser.
  assign vec_ack = {vec_ack_b, vec_ack_a};

  // Next-state logic for the pin path, the latches and the bus slave.
  always_comb begin
    state_next = state_reg;
    // The bus answers one cycle after it sees a request; the write lands at the edge the master sees the answer.
    wr_take = !state_reg.bus_wait && write;
    rd_take = state_reg.bus_wait && read;
    // Clear strobes exist only in the cycle in which a write is taken.
    sw_clr_raw = 2'h0;
    if (wr_take && byteenable[0] && address == EISC_STAT_CTRL_ADDR) begin
      sw_clr_raw[EISC_PIN_A] = writedata[EISC_PIN_A_CLEAR_BIT];
      sw_clr_raw[EISC_PIN_B] = writedata[EISC_PIN_B_CLEAR_BIT];
    end
    // During break, software clears are dropped unless break clears are allowed.
    sw_clr = (break_active && !state_reg.brk_allow) ? 2'h0 : sw_clr_raw; // [RQ14]

    // Both pins share one body; only pin B has the latch-off gate.
    for (int i = 0; i < 2; i++) begin
      // Three-stage synchroniser; only the second and third stages are compared.
      state_next.sync[i] = {state_reg.sync[i][EISC_SYNC_DEPTH-2:0], (i == 0) ? ext_int_pin_a : ext_int_pin_b}; // [RQ15]
      if (state_reg.sync[i][1] == state_reg.sync[i][2]) begin
        // A level change counts only once the two later stages agree.
        state_next.lvl[i] = state_reg.sync[i][2]; // [RQ15]
      end
      // A falling edge is a drop of the accepted level.
      fall[i] = state_reg.lvl[i] && !state_next.lvl[i]; // [RQ15]
      pin_high[i] = state_next.lvl[i];
      // Level holding applies only while the pin may latch at all.
      hold_low[i] = state_reg.sense[i] && !pin_high[i]; // [RQ5] [RQ10]
      if (i == EISC_PIN_B && state_reg.latch_off) begin
        // Pin B is cut off from its latch: no edge and no level reaches it.
        hold_low[i] = 1'b0; // [RQ6]
      end
      set_ev[i] = (fall[i] || hold_low[i]) && !(i == EISC_PIN_B && state_reg.latch_off); // [RQ6] [RQ13]

      if (set_ev[i]) begin
        // A new request wins over any acknowledge in the same cycle.
        state_next.latch[i] = 1'b1; // [RQ13]
        if (vec_ack[i] || sw_clr[i]) begin
          // In level mode, an acknowledge while the pin is still low is remembered for its return high.
          state_next.ack_seen[i] = hold_low[i]; // [RQ12]
        end
      end else if (vec_ack[i] || sw_clr[i]) begin
        // Edge-only mode, or the pin already high: the acknowledge clears at once.
        state_next.latch[i] = 1'b0; // [RQ2] [RQ7] [RQ11]
        state_next.ack_seen[i] = 1'b0;
      end else if (state_reg.ack_seen[i] && pin_high[i]) begin
        // Level mode: the remembered acknowledge completes when the pin returns high.
        state_next.latch[i] = 1'b0; // [RQ12]
        state_next.ack_seen[i] = 1'b0;
      end else if (!state_reg.latch[i]) begin
        // Nothing pending, so nothing is remembered.
        state_next.ack_seen[i] = 1'b0;
      end
    end

    // Register writes take effect at the edge the master sees waitrequest low.
    if (wr_take && byteenable[0]) begin
      unique case (address)
        EISC_STAT_CTRL_ADDR: begin
          // Clear bits are strobes only and are never stored.
          state_next.block[EISC_PIN_B] = writedata[EISC_PIN_B_BLOCK_BIT]; // [RQ4]
          state_next.sense[EISC_PIN_B] = writedata[EISC_PIN_B_SENSE_BIT]; // [RQ5]
          state_next.latch_off = writedata[EISC_PIN_B_OFF_BIT]; // [RQ6]
          state_next.block[EISC_PIN_A] = writedata[EISC_PIN_A_BLOCK_BIT]; // [RQ9]
          state_next.sense[EISC_PIN_A] = writedata[EISC_PIN_A_SENSE_BIT]; // [RQ10]
        end
        EISC_BREAK_CTRL_ADDR: begin
          // Break clear permission.
          state_next.brk_allow = writedata[EISC_BREAK_ALLOW_BIT]; // [RQ14]
        end
        default: begin
          // Unmapped or read-only addresses ignore writes.
          state_next.brk_allow = state_reg.brk_allow;
        end
      endcase
    end

    // Read data is captured with the answer and stands while waitrequest is low.
    if (rd_take) begin
      state_next.rdata = '0;
      unique case (address)
        EISC_STAT_CTRL_ADDR: begin
          // Clear bits read as zero because they are not stored.
          state_next.rdata[EISC_PIN_B_LEVEL_BIT] = state_reg.lvl[EISC_PIN_B]; // [RQ1]
          state_next.rdata[EISC_PIN_B_CLEAR_BIT] = 1'b0; // [RQ3]
          state_next.rdata[EISC_PIN_B_BLOCK_BIT] = state_reg.block[EISC_PIN_B];
          state_next.rdata[EISC_PIN_B_SENSE_BIT] = state_reg.sense[EISC_PIN_B];
          state_next.rdata[EISC_PIN_B_OFF_BIT] = state_reg.latch_off;
          state_next.rdata[EISC_PIN_A_CLEAR_BIT] = 1'b0; // [RQ8]
          state_next.rdata[EISC_PIN_A_BLOCK_BIT] = state_reg.block[EISC_PIN_A];
          state_next.rdata[EISC_PIN_A_SENSE_BIT] = state_reg.sense[EISC_PIN_A];
        end
        EISC_BREAK_CTRL_ADDR: begin
          // Break clear permission reads back.
          state_next.rdata[EISC_BREAK_ALLOW_BIT] = state_reg.brk_allow;
        end
        EISC_LATCH_STAT_ADDR: begin
          // Latch states and pin A level, for polling software.
          state_next.rdata[EISC_LATCH_A_BIT] = state_reg.latch[EISC_PIN_A];
          state_next.rdata[EISC_LATCH_B_BIT] = state_reg.latch[EISC_PIN_B];
          state_next.rdata[EISC_PIN_A_LEVEL_BIT] = state_reg.lvl[EISC_PIN_A];
        end
        default: begin
          // Unmapped addresses read as zero.
          state_next.rdata = '0;
        end
      endcase
    end

    // One answer cycle per request; the flag drops right after it is seen.
    // Holding the flag in waitrequest polarity keeps waitrequest a direct flop output with no gate after it.
    state_next.bus_wait = !(state_reg.bus_wait && (read || write));

    // Requests follow the latch, held back by the block bits.
    state_next.req = state_next.latch & ~state_next.block; // [RQ4] [RQ9]
  end

  // State register; reset clears latches and control and parks the pin path high.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.sync <= {2{{EISC_SYNC_DEPTH{EISC_PIN_IDLE}}}};
      state_reg.lvl <= {2{EISC_PIN_IDLE}};
      state_reg.latch <= 2'h0; // [RQ11]
      state_reg.ack_seen <= 2'h0;
      state_reg.block <= {2{EISC_CTRL_RST}};
      state_reg.sense <= {2{EISC_CTRL_RST}};
      state_reg.latch_off <= EISC_CTRL_RST;
      state_reg.brk_allow <= EISC_CTRL_RST;
      // The wait flag comes up high, so waitrequest is high in and right after reset.
      state_reg.bus_wait <= EISC_WAIT_RST;
      state_reg.rdata <= '0;
      state_reg.req <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flops.
  assign readdata = state_reg.rdata;
  // The stored wait flag is waitrequest itself.
  assign waitrequest = state_reg.bus_wait;
  assign irq_req_a = state_reg.req[EISC_PIN_A];
  assign irq_req_b = state_reg.req[EISC_PIN_B];

  // Checks run on the single clock and pause during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // The pin B level bit returns the accepted level seen when the read is taken.
  pin_b_read_a: assert property (rd_take && address == EISC_STAT_CTRL_ADDR |=> // [RQ1]
    readdata[EISC_PIN_B_LEVEL_BIT] == $past(state_reg.lvl[EISC_PIN_B]))
    else $error("pin B level bit does not match pin");

  // Clear bits of a status/control read never come back as one.
  clear_bits_zero_a: assert property (rd_take && address == EISC_STAT_CTRL_ADDR |=> // [RQ3]
    !readdata[EISC_PIN_B_CLEAR_BIT] && !readdata[EISC_PIN_A_CLEAR_BIT])
    else $error("clear bit read back as one");

  // A taken pin B clear in edge mode empties the latch when no new request arrives.
  clear_b_works_a: assert property (sw_clr[EISC_PIN_B] && !set_ev[EISC_PIN_B] |=> // [RQ2]
    !state_reg.latch[EISC_PIN_B])
    else $error("pin B clear did not clear latch");

  // A taken pin A clear empties the latch when no new request arrives.
  clear_a_works_a: assert property (sw_clr[EISC_PIN_A] && !set_ev[EISC_PIN_A] |=> // [RQ7]
    !state_reg.latch[EISC_PIN_A])
    else $error("pin A clear did not clear latch");

  // A blocked pin never shows a request.
  block_b_gate_a: assert property (state_reg.block[EISC_PIN_B] |-> !irq_req_b) // [RQ4]
    else $error("pin B request while blocked");

  block_a_gate_a: assert property (state_reg.block[EISC_PIN_A] |-> !irq_req_a) // [RQ9]
    else $error("pin A request while blocked");

  // An unblocked latch shows a request in the same cycle.
  req_follows_a: assert property (state_reg.latch[EISC_PIN_A] && !state_reg.block[EISC_PIN_A] |-> irq_req_a) // [RQ9]
    else $error("pin A latch set but no request");

  // Edge-only mode: a steady low pin does not set a clear latch.
  edge_only_b_a: assert property (!state_reg.sense[EISC_PIN_B] && !state_reg.latch[EISC_PIN_B] // [RQ5]
    && !fall[EISC_PIN_B] |=> !state_reg.latch[EISC_PIN_B])
    else $error("pin B latched without an edge");

  // Level mode: an accepted low level sets the latch on the next edge.
  level_sets_a: assert property (state_reg.sense[EISC_PIN_A] && !state_next.lvl[EISC_PIN_A] |=> // [RQ10]
    state_reg.latch[EISC_PIN_A])
    else $error("pin A low level did not latch");

  // Latch-off keeps a clear pin B latch clear in the next cycle.
  latch_off_b_a: assert property (state_reg.latch_off && !state_reg.latch[EISC_PIN_B] // [RQ6]
    ##1 state_reg.latch_off |-> !state_reg.latch[EISC_PIN_B])
    else $error("pin B latched while cut off");

  // A vector fetch clears its latch when no request holds it.
  vector_clears_a: assert property (vec_ack[EISC_PIN_A] && !set_ev[EISC_PIN_A] |=> // [RQ11]
    !state_reg.latch[EISC_PIN_A])
    else $error("vector fetch did not clear pin A latch");

  // Level mode keeps the latch while the pin stays low, acknowledge or not.
  level_hold_a: assert property (state_reg.sense[EISC_PIN_A] && state_reg.latch[EISC_PIN_A] // [RQ12]
    && !state_next.lvl[EISC_PIN_A] |=> state_reg.latch[EISC_PIN_A])
    else $error("pin A latch dropped while pin low");

  // An accepted falling edge on pin A always sets its latch.
  edge_sets_a: assert property (fall[EISC_PIN_A] |=> state_reg.latch[EISC_PIN_A]) // [RQ13]
    else $error("falling edge lost on pin A");

  // During protected break a software clear leaves a set latch alone.
  break_guard_a: assert property (break_active && !state_reg.brk_allow && state_reg.latch[EISC_PIN_B] // [RQ14]
    && !vec_ack[EISC_PIN_B] && !state_reg.ack_seen[EISC_PIN_B] |=> state_reg.latch[EISC_PIN_B])
    else $error("pin B latch cleared during protected break");

  // An edge is only seen after the two later synchroniser stages agree low.
  sync_edge_a: assert property (fall[EISC_PIN_B] |-> !state_reg.sync[EISC_PIN_B][1] // [RQ15]
    && !state_reg.sync[EISC_PIN_B][2] && state_reg.lvl[EISC_PIN_B])
    else $error("edge detected from unsettled samples");

  // Every request is answered on the next cycle.
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one cycle");

  // The pin A level bit of the latch status word follows the accepted level.
  pin_a_read_a: assert property (rd_take && address == EISC_LATCH_STAT_ADDR |=>
    readdata[EISC_PIN_A_LEVEL_BIT] == $past(state_reg.lvl[EISC_PIN_A]))
    else $error("pin A level bit does not match pin");

  // A taken write stores the pin A block bit as written.
  block_a_write_a: assert property (wr_take && byteenable[0] && address == EISC_STAT_CTRL_ADDR |=> // [RQ9]
    state_reg.block[EISC_PIN_A] == $past(writedata[EISC_PIN_A_BLOCK_BIT]))
    else $error("pin A block bit not written");

  // A taken write stores the pin B sense bit as written.
  sense_b_write_a: assert property (wr_take && byteenable[0] && address == EISC_STAT_CTRL_ADDR |=> // [RQ5]
    state_reg.sense[EISC_PIN_B] == $past(writedata[EISC_PIN_B_SENSE_BIT]))
    else $error("pin B sense bit not written");

  // A vector fetch clears the pin B latch when no request holds it.
  vector_b_clears_a: assert property (vec_ack[EISC_PIN_B] && !set_ev[EISC_PIN_B] |=> // [RQ11]
    !state_reg.latch[EISC_PIN_B])
    else $error("vector fetch did not clear pin B latch");

  // Level mode: a remembered acknowledge completes once the pin is high again.
  level_release_a: assert property (state_reg.ack_seen[EISC_PIN_A] && state_next.lvl[EISC_PIN_A] |=> // [RQ12]
    !state_reg.latch[EISC_PIN_A])
    else $error("pin A latch kept after acknowledge and pin high");

  // Level mode on pin B holds the latch while the pin stays low, unless latching is off.
  level_hold_b_a: assert property (state_reg.sense[EISC_PIN_B] && !state_reg.latch_off // [RQ12]
    && state_reg.latch[EISC_PIN_B] && !state_next.lvl[EISC_PIN_B] |=> state_reg.latch[EISC_PIN_B])
    else $error("pin B latch dropped while pin low");

  // An accepted falling edge on pin B sets its latch unless latching is off.
  edge_sets_b_a: assert property (fall[EISC_PIN_B] && !state_reg.latch_off |=> // [RQ13]
    state_reg.latch[EISC_PIN_B])
    else $error("falling edge lost on pin B");

  // With break clears allowed, a software clear during break still empties the latch.
  break_allow_a: assert property (break_active && state_reg.brk_allow && sw_clr_raw[EISC_PIN_A] // [RQ14]
    && !set_ev[EISC_PIN_A] |=> !state_reg.latch[EISC_PIN_A])
    else $error("allowed clear during break had no effect");

  // The answer cycle never lasts longer than one clock.
  answer_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Main scenarios; they show that the bench reaches the clear, level and break paths.
  latch_a_set_c: cover property (fall[EISC_PIN_A] ##1 irq_req_a);
  break_allow_c: cover property (break_active && state_reg.brk_allow && sw_clr[EISC_PIN_A] ##1 !state_reg.latch[EISC_PIN_A]);
  clear_b_c: cover property (state_reg.latch[EISC_PIN_B] ##1 sw_clr[EISC_PIN_B] ##1 !state_reg.latch[EISC_PIN_B]);
  level_ack_c: cover property (state_reg.ack_seen[EISC_PIN_A] ##[1:20] !state_reg.latch[EISC_PIN_A]);
  break_block_c: cover property (sw_clr_raw[EISC_PIN_B] && !sw_clr[EISC_PIN_B] && state_reg.latch[EISC_PIN_B]);

endmodule

`default_nettype wire

//--- testbench/eisc_partner.sv
// Model of the interrupt pins and of the CPU logic that answers requests with a vector fetch.
`timescale 1ns/1ps
`default_nettype none

module eisc_partner
  import eisc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] pin_cmd,
  input wire logic fetch_en,
  input wire logic fetch_slow,
  input wire logic irq_req_a,
  input wire logic irq_req_b,
  output logic ext_int_pin_a,
  output logic ext_int_pin_b,
  output logic vec_ack_a,
  output logic vec_ack_b
);
  logic [2:0] wait_cnt; // Cycles spent before fetching the vector.
  logic served; // One fetch per enable, so a held request is not acknowledged twice.

  // The pins are driven at all times; an idle pin sits high like a pulled-up line.
  assign ext_int_pin_a = pin_cmd[EISC_PIN_A];
  assign ext_int_pin_b = pin_cmd[EISC_PIN_B];

  // The CPU fetches the vector of the pending request, at once or after a few cycles.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 3'h0;
      served <= 1'h0;
      vec_ack_a <= 1'h0;
      vec_ack_b <= 1'h0;
    end else begin
      vec_ack_a <= 1'h0;
      vec_ack_b <= 1'h0;
      if (!fetch_en) begin
        served <= 1'h0;
        wait_cnt <= 3'h0;
      end else if (!served && (irq_req_a || irq_req_b)) begin
        if (wait_cnt == (fetch_slow ? 3'h5 : 3'h0)) begin
          // Pin A has priority; the acknowledge is a one-cycle pulse.
          vec_ack_a <= irq_req_a;
          vec_ack_b <= !irq_req_a;
          served <= 1'h1;
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking testbench of the external interrupt status/control block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import eisc_pkg::*;
  logic clk = 1'h0; // 25 MHz bus clock.
  logic rst_b = 1'h0; // Reset held low from time zero.
  logic [1:0] pin_cmd = 2'h3; // Wanted pin levels, index by pin.
  logic fetch_en = 1'h0;
  logic fetch_slow = 1'h0;
  logic break_active = 1'h0;
  logic [EISC_ADDR_W-1:0] address = '0;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [EISC_DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = 4'h0;
  logic [EISC_DATA_W-1:0] readdata;
  logic waitrequest, irq_req_a, irq_req_b, ext_int_pin_a, ext_int_pin_b, vec_ack_a, vec_ack_b;
  logic [EISC_DATA_W+1:0] exp_q[$]; // Expected {irq B, irq A, readdata} per read.
  logic [EISC_DATA_W+1:0] e;
  logic [7:0] ctrl; // Model of the stored control bits.
  logic [1:0] lat; // Model of the two latches.
  logic brk = 1'h0; // Model of the break clear permission.
  logic [31:0] r;
  int err_total = 0;
  int n_tests = 0;
  int seed;
  int k;

  always #20 clk = ~clk;

  eisc_top dut (.clk(clk), .rst_b(rst_b), .ext_int_pin_a(ext_int_pin_a), .ext_int_pin_b(ext_int_pin_b),
    .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b), .break_active(break_active), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq_req_a(irq_req_a), .irq_req_b(irq_req_b));

  eisc_partner partner (.clk(clk), .rst_b(rst_b), .pin_cmd(pin_cmd), .fetch_en(fetch_en),
    .fetch_slow(fetch_slow), .irq_req_a(irq_req_a), .irq_req_b(irq_req_b), .ext_int_pin_a(ext_int_pin_a),
    .ext_int_pin_b(ext_int_pin_b), .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b));

  // Prints the verdict and stops; every path out of the run ends here.
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One Avalon access; the request is held until waitrequest is seen low at an edge.
  task automatic bus_op(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= rd;
    write <= !rd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'h0 && k < 50);
    read <= 1'h0;
    write <= 1'h0;
    if (k >= 50) begin
      err_total++;
      complete_run();
    end
  endtask

  // Writes the control register with random upper bits and updates the model.
  task automatic wctrl(input logic [7:0] d);
    r = $random(seed);
    bus_op(1'h0, EISC_STAT_CTRL_ADDR, {r[31:8], d}, {r[3:1], 1'h1});
    ctrl = d & 8'h3B;
    // A software clear is ignored in break unless allowed; level mode holds while the pin is low.
    if (!break_active || brk) begin
      if (d[2] && !(ctrl[0] && !pin_cmd[0])) lat[0] = 1'h0;
      if (d[6] && !(ctrl[4] && !ctrl[3] && !pin_cmd[1])) lat[1] = 1'h0;
    end
  endtask

  // Reads both status words, noting the expected values first.
  task automatic chk();
    exp_q.push_back({lat & ~{ctrl[5], ctrl[1]}, 24'h0, pin_cmd[1], 1'h0, ctrl[5:3], 1'h0, ctrl[1:0]});
    bus_op(1'h1, EISC_STAT_CTRL_ADDR, 32'h0, 4'hF);
    exp_q.push_back({lat & ~{ctrl[5], ctrl[1]}, 29'h0, pin_cmd[0], lat});
    bus_op(1'h1, EISC_LATCH_STAT_ADDR, 32'h0, 4'hF);
  endtask

  // Moves one pin and waits past the synchroniser lag.
  task automatic pin(input int p, input logic v);
    @(posedge clk);
    pin_cmd[p] <= v;
    repeat (6) @(posedge clk);
  endtask

  // Watcher: each read answer is compared with the oldest note.
  always @(posedge clk) begin
    if (read && waitrequest === 1'h0) begin
      n_tests++;
      e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      if ({irq_req_b, irq_req_a, readdata} !== e) begin
        err_total++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, {irq_req_b, irq_req_a, readdata});
      end
    end
  end

  // Main sequence.
  initial begin
    seed = 32'hDAAA744A;
    ctrl = 8'h00;
    lat = 2'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    chk();
    exp_q.push_back('0);
    bus_op(1'h1, 4'hC, 32'h0, 4'hF);
    // Random control values, some with the low byte lane disabled so nothing changes.
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      bus_op(1'h0, EISC_STAT_CTRL_ADDR, r, r[11:8]);
      if (r[8]) ctrl = r[7:0] & 8'h3B;
      chk();
    end
    // Both pins, edge mode then edge-plus-level mode.
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 2; m++) begin
        wctrl(m ? (p ? 8'h10 : 8'h01) : 8'h00);
        pin(p, 1'h0);
        lat[p] = 1'h1;
        chk();
        wctrl(ctrl | (p ? 8'h40 : 8'h04));
        chk();
        pin(p, 1'h1);
        lat[p] = 1'h0;
        chk();
        pin(p, 1'h0);
        lat[p] = 1'h1;
        wctrl(ctrl | (p ? 8'h20 : 8'h02));
        chk();
        wctrl(ctrl & (p ? 8'hDF : 8'hFD));
        fetch_slow <= m[0];
        fetch_en <= 1'h1;
        k = 0;
        while ((p ? vec_ack_b : vec_ack_a) !== 1'h1 && k < 20) begin
          @(posedge clk);
          k++;
        end
        if (k >= 20) begin
          err_total++;
          complete_run();
        end
        fetch_en <= 1'h0;
        lat[p] = m[0];
        chk();
        pin(p, 1'h1);
        lat[p] = 1'h0;
        chk();
      end
    end
    // Latch-off: pin B falls but nothing is latched; its level still shows.
    wctrl(8'h08);
    pin(1, 1'h0);
    chk();
    pin(1, 1'h1);
    wctrl(8'h00);
    // Break: a software clear is ignored until clearing is allowed, and stays done after break.
    break_active <= 1'h1;
    pin(0, 1'h0);
    pin(0, 1'h1);
    lat[0] = 1'h1;
    wctrl(8'h04);
    chk();
    bus_op(1'h0, EISC_BREAK_CTRL_ADDR, 32'h1, 4'hF);
    brk = 1'h1;
    exp_q.push_back({lat, 32'h1});
    bus_op(1'h1, EISC_BREAK_CTRL_ADDR, 32'h0, 4'hF);
    wctrl(8'h04);
    break_active <= 1'h0;
    chk();
    bus_op(1'h0, EISC_BREAK_CTRL_ADDR, 32'h0, 4'hF);
    brk = 1'h0;
    // Reset in mid-run clears both latches and all control bits.
    pin(0, 1'h0);
    pin(0, 1'h1);
    pin(1, 1'h0);
    pin(1, 1'h1);
    lat = 2'h3;
    wctrl(8'h3B);
    chk();
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    ctrl = 8'h00;
    lat = 2'h0;
    chk();
    complete_run();
  end
endmodule

`default_nettype wire
